// File: fault_notify_pkg.sv
package fault_notify_pkg;

  // ---------------------------------------------------------------
  // Bus geometry and register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CFG      = 8'h04;
  localparam logic [7:0] ADDR_PSTATUS  = 8'h08;
  localparam logic [7:0] ADDR_PIN      = 8'h0c;
  localparam logic [7:0] ADDR_PERR     = 8'h10;
  localparam logic [7:0] ADDR_SERR     = 8'h14;
  localparam logic [7:0] ADDR_SSTATUS  = 8'h18;

  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_CLEAR_PRI   = 0;
  localparam int CTRL_CLEAR_SEC   = 1;
  localparam int CFG_MASK_A       = 0;
  localparam int CFG_MASK_B       = 1;
  localparam int CFG_PAR_INJECT   = 7;
  localparam int ERR_CLASS_A      = 0;
  localparam int ERR_CLASS_B      = 1;
  localparam int ERR_COMM_LOSS    = 2;
  localparam int ERR_MEMORY       = 3;

  // Synchroniser lanes
  localparam int SY_EN    = 0;
  localparam int SY_ASNS  = 1;
  localparam int SY_BSNS  = 2;
  localparam int SY_SECA  = 3;
  localparam int SY_SECB  = 4;
  localparam int SY_LS    = 5;
  localparam int SY_PRI_REF_CURRENT_PIN = 6;
  localparam int SY_SEC_REF_CURRENT_PIN = 7;
  localparam int SY_SMEM  = 8;
  localparam int SY_W     = 9;

  // ---------------------------------------------------------------
  // Operating mode codes and lifesign timing (cycles of aclk)
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_0 = 3'h0;
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;

  localparam logic [11:0] LS_PERIOD_CYC = 12'h064;
  localparam logic [11:0] LS_WIN_MIN    = 12'h032;
  localparam logic [11:0] LS_WIN_MAX    = 12'h096;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_FAULT_A_N = 1'b1;
  localparam logic RST_FAULT_B_N = 1'b0;
  localparam logic RST_READY_N   = 1'b0;
  localparam logic RST_SDO_LOW   = 1'b1;
  localparam logic RST_DISABLED  = 1'b1;

endpackage

// File: fault_notify_supervision.sv
// Behaviour
// - Three active-low notification pins plus error bits
// - Secondary class A status mirrored to primary
// - Secondary class B status mirrored to primary
// - Class A pin only on 4->3/6->5, tristate
// - Class B pin on entry to mode 1, missed lifesign, primary hold
// - Driven and sensed fault pin levels readable
// - Clear-primary clears primary stickies except memory failure, releases pins
// - Clear-secondary clears secondary stickies only
// - Clear-secondary in mode 1 requests mode 0
// - Enable rising releases pins in modes 3/5
// - Class A mask gates clear-primary release
// - Class B mask gates clear-primary release
// - Enable high valid; falling raises class A
// - Sensed enable level and validity readable
// - Missed lifesign: mode 0, class B, losses
// - Loss bits sticky, secondary-ready shows present
// - Reference-current fault holds primary in reset
// - Secondary reference fault: emergency off, hold
// - Configuration parity checked as memory failure
// - Primary memory failure: hold, pins, secondary off
// - Secondary memory failure: emergency off, hold
// - Primary reset pin levels fixed
`timescale 1ns/1ns
`default_nettype none

module fault_notify_supervision (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [fault_notify_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [fault_notify_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic                            enable_pin,
  input  wire logic                            class_a_pin_level,
  input  wire logic                            class_b_pin_level,
  input  wire logic                            sec_class_a_in,
  input  wire logic                            sec_class_b_in,
  input  wire logic                            lifesign_in,
  input  wire logic                            pri_ref_current_fail,
  input  wire logic                            sec_ref_current_fail,
  input  wire logic                            sec_memory_fail,
  input  wire logic [2:0]                      op_mode,
  input  wire logic                            class_a_event,
  input  wire logic                            class_b_event,
  input  wire logic                            tristate_event,
  output logic                                 class_a_fault_n,
  output logic                                 class_b_fault_n,
  output logic                                 reset_ready_n,
  output logic                                 sdo_low,
  output logic                                 mode_zero_req,
  output logic                                 enable_class_a_event,
  output logic                                 device_disabled,
  output logic                                 lifesign_out,
  output logic                                 sec_emergency_off,
  output logic                                 sec_hold_reset
);
  import fault_notify_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [SY_W-1:0]   sync1;
    logic [SY_W-1:0]   sync2;
    logic [SY_W-1:0]   prev;
    logic [2:0]        mode_prev;
    logic              fa_n;
    logic              fb_n;
    logic              rr_n;
    logic              sdo_low;
    logic              mode0_req;
    logic              en_a_evt;
    logic              disabled;
    logic              sec_off;
    logic              sec_hold;
    logic              ls_out;
    logic [11:0]       ls_tx_cnt;
    logic [11:0]       ls_rx_cnt;
    logic              srdy;
    logic [1:0]        cfg_mask;
    logic              cfg_par;
    logic [3:0]        pri_err;
    logic [2:0]        sec_err;
    logic              awrdy;
    logic              wrdy;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic              wstrb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic wr_fire;
  logic clr_p;
  logic clr_s;
  logic pri_hold;
  logic ls_edge;
  logic ls_err;
  logic en_rise;
  logic en_fall;
  logic a_set;
  logic b_set;
  logic a_rel;
  logic b_rel;
  logic par_bad;
  logic rd_hit;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Floating enable is pulled low off-chip and so reads invalid
    s_next.sync1 = {sec_memory_fail, sec_ref_current_fail, pri_ref_current_fail,
                    lifesign_in, sec_class_b_in, sec_class_a_in,
                    class_b_pin_level, class_a_pin_level, enable_pin};
    s_next.sync2 = s_reg.sync1;
    s_next.prev = s_reg.sync2;
    s_next.mode_prev = op_mode;
    s_next.mode0_req = 1'b0;

    en_rise = s_reg.sync2[SY_EN] & ~s_reg.prev[SY_EN];
    en_fall = ~s_reg.sync2[SY_EN] & s_reg.prev[SY_EN];
    ls_edge = s_reg.sync2[SY_LS] ^ s_reg.prev[SY_LS];
    pri_hold = s_reg.sync2[SY_PRI_REF_CURRENT_PIN] | s_reg.pri_err[ERR_MEMORY];
    par_bad = ^{s_reg.cfg_mask, s_reg.cfg_par};

    // Register writes
    wr_fire = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
    clr_p = wr_fire & s_reg.wstrb0 & (s_reg.awaddr == ADDR_CTRL) & s_reg.wdata[CTRL_CLEAR_PRI];
    clr_s = wr_fire & s_reg.wstrb0 & (s_reg.awaddr == ADDR_CTRL) & s_reg.wdata[CTRL_CLEAR_SEC];
    if (wr_fire && s_reg.wstrb0 && (s_reg.awaddr == ADDR_CFG)) begin
      // Parity stored beside the masks; bit 7 lets software seed a fault
      s_next.cfg_mask = s_reg.wdata[1:0];
      s_next.cfg_par = (^s_reg.wdata[1:0]) ^ s_reg.wdata[CFG_PAR_INJECT];
    end

    // Enable validity and its class A event
    s_next.disabled = ~s_reg.sync2[SY_EN];
    s_next.en_a_evt = en_fall;

    // Lifesign transmit: stops while primary is held, so secondary resets
    if (pri_hold) begin
      s_next.ls_tx_cnt = '0;
    end else if (s_reg.ls_tx_cnt == LS_PERIOD_CYC - 12'h001) begin
      s_next.ls_tx_cnt = '0;
      s_next.ls_out = ~s_reg.ls_out;
    end else begin
      s_next.ls_tx_cnt = s_reg.ls_tx_cnt + 12'h001;
    end

    // Lifesign receive window
    ls_err = 1'b0;
    if (pri_hold) begin
      s_next.ls_rx_cnt = '0;
      s_next.srdy = 1'b0;
    end else if (ls_edge) begin
      s_next.ls_rx_cnt = '0;
      if (s_reg.ls_rx_cnt < LS_WIN_MIN) begin
        ls_err = 1'b1;
      end else begin
        s_next.srdy = 1'b1;
      end
    end else if (s_reg.ls_rx_cnt == LS_WIN_MAX) begin
      s_next.ls_rx_cnt = '0;
      ls_err = 1'b1;
    end else begin
      s_next.ls_rx_cnt = s_reg.ls_rx_cnt + 12'h001;
    end
    if (ls_err) begin
      s_next.srdy = 1'b0;
      s_next.mode0_req = 1'b1;
    end
    if (clr_s && op_mode == MODE_1) begin
      s_next.mode0_req = 1'b1;
    end

    // Sticky errors; a set in the clearing cycle wins
    s_next.pri_err[ERR_CLASS_A] = (s_reg.pri_err[ERR_CLASS_A] & ~clr_p)
                                | class_a_event | en_fall | tristate_event;
    s_next.pri_err[ERR_CLASS_B] = (s_reg.pri_err[ERR_CLASS_B] & ~clr_p) | class_b_event;
    s_next.pri_err[ERR_COMM_LOSS] = (s_reg.pri_err[ERR_COMM_LOSS] & ~clr_p) | ls_err;
    // Memory failure survives every clear: only aresetn removes it
    s_next.pri_err[ERR_MEMORY] = s_reg.pri_err[ERR_MEMORY] | par_bad;
    s_next.sec_err[ERR_CLASS_A] = (s_reg.sec_err[ERR_CLASS_A] & ~clr_s)
                                | (s_reg.sync2[SY_SECA] & ~s_reg.prev[SY_SECA]);
    s_next.sec_err[ERR_CLASS_B] = (s_reg.sec_err[ERR_CLASS_B] & ~clr_s)
                                | (s_reg.sync2[SY_SECB] & ~s_reg.prev[SY_SECB]);
    s_next.sec_err[ERR_COMM_LOSS] = (s_reg.sec_err[ERR_COMM_LOSS] & ~clr_s) | ls_err;

    // Fault pins: assertion outranks a release in the same cycle; primary hold forces reset levels over both
    a_set = ((s_reg.mode_prev == MODE_4) && (op_mode == MODE_3))
          || ((s_reg.mode_prev == MODE_6) && (op_mode == MODE_5))
          || tristate_event;
    b_set = ((op_mode == MODE_1) && (s_reg.mode_prev != MODE_1)) || ls_err;
    a_rel = (en_rise && (op_mode == MODE_3 || op_mode == MODE_5))
          || (clr_p && (!s_reg.cfg_mask[CFG_MASK_A]
                        || (!s_reg.sync2[SY_SECA] && s_reg.sync2[SY_EN])));
    b_rel = (en_rise && (op_mode == MODE_3 || op_mode == MODE_5))
          || (clr_p && (!s_reg.cfg_mask[CFG_MASK_B]
                        || (!s_reg.sync2[SY_SECB] && s_reg.srdy)));
    if (a_set) begin
      s_next.fa_n = 1'b0;
    end else if (a_rel) begin
      s_next.fa_n = 1'b1;
    end
    if (b_set) begin
      s_next.fb_n = 1'b0;
    end else if (b_rel) begin
      s_next.fb_n = 1'b1;
    end

    if (pri_hold) begin
      s_next.fa_n = RST_FAULT_A_N;
      s_next.fb_n = RST_FAULT_B_N;
      s_next.rr_n = RST_READY_N;
      s_next.sdo_low = RST_SDO_LOW;
    end else begin
      s_next.rr_n = 1'b1;
      s_next.sdo_low = 1'b0;
    end

    // Secondary-side failure reactions
    s_next.sec_off = s_reg.pri_err[ERR_MEMORY] | s_reg.sync2[SY_SEC_REF_CURRENT_PIN]
                   | s_reg.sync2[SY_SMEM];
    s_next.sec_hold = s_reg.sync2[SY_SEC_REF_CURRENT_PIN] | s_reg.sync2[SY_SMEM];

    // AXI write channels
    if (s_axi_awvalid && s_reg.awrdy) begin
      s_next.aw_held = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wrdy) begin
      s_next.w_held = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = (s_reg.awaddr == ADDR_CTRL || s_reg.awaddr == ADDR_CFG)
                   ? RESP_OKAY : RESP_SLVERR;
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awrdy = ~s_next.aw_held & ~s_next.bvalid;
    s_next.wrdy = ~s_next.w_held & ~s_next.bvalid;

    // AXI read channels
    rd_hit = 1'b1;
    if (s_axi_arvalid && s_reg.arrdy) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = '0;
      case (s_axi_araddr)
        ADDR_CTRL: s_next.rdata = '0;
        ADDR_CFG: s_next.rdata = {30'h0, s_reg.cfg_mask};
        ADDR_PSTATUS: s_next.rdata = {26'h0, s_reg.srdy, s_reg.sync2[SY_EN],
                                      s_reg.sync2[SY_SECB], s_reg.sync2[SY_SECA],
                                      s_reg.fb_n, s_reg.fa_n};
        ADDR_PIN: s_next.rdata = {29'h0, s_reg.sync2[SY_EN], s_reg.sync2[SY_BSNS],
                                  s_reg.sync2[SY_ASNS]};
        ADDR_PERR: s_next.rdata = {28'h0, s_reg.pri_err};
        ADDR_SERR: s_next.rdata = {29'h0, s_reg.sec_err};
        ADDR_SSTATUS: s_next.rdata = {30'h0, s_reg.sync2[SY_SECB], s_reg.sync2[SY_SECA]};
        default: rd_hit = 1'b0;
      endcase
      s_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    s_next.arrdy = ~s_next.rvalid;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.fa_n <= RST_FAULT_A_N;
      s_reg.fb_n <= RST_FAULT_B_N;
      s_reg.rr_n <= RST_READY_N;
      s_reg.sdo_low <= RST_SDO_LOW;
      s_reg.disabled <= RST_DISABLED;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awrdy;
  assign s_axi_wready = s_reg.wrdy;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arrdy;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign class_a_fault_n = s_reg.fa_n;
  assign class_b_fault_n = s_reg.fb_n;
  assign reset_ready_n = s_reg.rr_n;
  assign sdo_low = s_reg.sdo_low;
  assign mode_zero_req = s_reg.mode0_req;
  assign enable_class_a_event = s_reg.en_a_evt;
  assign device_disabled = s_reg.disabled;
  assign lifesign_out = s_reg.ls_out;
  assign sec_emergency_off = s_reg.sec_off;
  assign sec_hold_reset = s_reg.sec_hold;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_hold_pins: assert property (pri_hold |=>
    (class_a_fault_n && !class_b_fault_n && !reset_ready_n && sdo_low))
    else $error("held primary drives wrong pin levels");
  chk_sec_sticky: assert property ($rose(s_reg.sync2[SY_SECA]) && !clr_s |=>
    s_reg.sec_err[ERR_CLASS_A] ##1 (s_reg.sec_err[ERR_CLASS_A] || $past(clr_s)))
    else $error("secondary class A sticky not set");
  chk_clr_a_free: assert property (
    clr_p && !s_reg.cfg_mask[CFG_MASK_A] && !a_set && !pri_hold |=> class_a_fault_n)
    else $error("unmasked clear did not release class A pin");
  chk_clr_a_mask: assert property (clr_p && s_reg.cfg_mask[CFG_MASK_A]
    && s_reg.sync2[SY_SECA] && !s_reg.fa_n && !en_rise && !pri_hold |=> !class_a_fault_n)
    else $error("masked clear released class A pin");
  chk_clr_b_mask: assert property (clr_p && s_reg.cfg_mask[CFG_MASK_B] && !s_reg.srdy
    && !s_reg.fb_n && !en_rise |=> !class_b_fault_n)
    else $error("masked clear released class B pin");
  chk_clrs_mode: assert property (clr_s && op_mode == MODE_1 |=> mode_zero_req)
    else $error("clear secondary in mode 1 gave no mode 0 request");
  chk_en_fall: assert property ($fell(s_reg.sync2[SY_EN]) |=>
    enable_class_a_event && device_disabled ##1 (s_reg.pri_err[ERR_CLASS_A] || $past(clr_p)))
    else $error("enable fall missed class A event");
  chk_ls_timeout: assert property (!pri_hold && !ls_edge
    && s_reg.ls_rx_cnt == LS_WIN_MAX |=> !class_b_fault_n && mode_zero_req
    && s_reg.sec_err[ERR_COMM_LOSS] && !s_reg.srdy)
    else $error("lifesign timeout reaction missing");
  chk_parity_mem: assert property (par_bad |=> s_reg.pri_err[ERR_MEMORY]
    ##1 !reset_ready_n && sec_emergency_off)
    else $error("parity fault not handled");
  chk_mode_b_pin: assert property (op_mode == MODE_1 && s_reg.mode_prev != MODE_1
    && !pri_hold |=> !class_b_fault_n)
    else $error("entry to mode 1 did not assert class B pin");

  cov_lifesign_ok: cover property (ls_edge && !ls_err ##1 s_reg.srdy);
  cov_clear_masked: cover property (clr_p && s_reg.cfg_mask[CFG_MASK_A] && !s_reg.fa_n);
  cov_en_release: cover property (en_rise && op_mode == MODE_3 && !s_reg.fa_n);

endmodule // fault_notify_supervision

`default_nettype wire

// File: fault_notify_supervision_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fault_notify_supervision_tb;
  import fault_notify_pkg::*;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        aclk, aresetn, enable_pin, sec_class_a_in, sec_class_b_in, lifesign_in;
  logic        pri_ref_current_fail, sec_ref_current_fail, sec_memory_fail, tristate_event;
  logic        class_a_event, class_b_event, class_a_fault_n, class_b_fault_n, reset_ready_n;
  logic        sdo_low, mode_zero_req, enable_class_a_event, device_disabled, lifesign_out;
  logic        sec_emergency_off, sec_hold_reset, ls_prev;
  logic [2:0]  op_mode;
  logic [11:0] period;
  int          n_fail, checks, mz_cnt, ev_cnt, ls_tog;
  wire logic   class_a_pin_level, class_b_pin_level;
  // Pull-ups on the pins: sensed level follows the driven one
  assign class_a_pin_level = class_a_fault_n;
  assign class_b_pin_level = class_b_fault_n;

  fault_notify_supervision DUT (.*);
  secondary_link_model peer (.aclk(aclk), .aresetn(aresetn), .period(period),
                             .hold(sec_hold_reset), .lifesign(lifesign_in));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (mode_zero_req === 1'b1) mz_cnt++;
    if (enable_class_a_event === 1'b1) ev_cnt++;
  end
  // Counted off the falling edge, half a cycle after launch, so window starts are race-free
  always @(negedge aclk) begin
    if (lifesign_out !== ls_prev) ls_tog++;
    ls_prev = lifesign_out;
  end
  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic end_of_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    end_of_test();
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 20) tmo();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 20) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    rdr(a, rd, rsp);
    chk(nm, e, rd & m);
  endtask
  task automatic pulse_mode(input logic [2:0] m);
    op_mode <= m;
    wt(3);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    wr(ADDR_CTRL, 32'h1, rsp);
    rc("pstatus", ADDR_PSTATUS, 32'h13, 32'h13);
    rc("pin", ADDR_PIN, 32'h7, 32'h7);
    rc("perr", ADDR_PERR, 32'hf, 32'h0);
    rc("ctrl", ADDR_CTRL, 32'h3, 32'h0);
    wr(8'h1c, 32'h1, rsp);
    chk("bresp", RESP_SLVERR, rsp);
    wr(ADDR_PSTATUS, 32'h1, rsp);
    chk("bresp", RESP_SLVERR, rsp);
    rdr(8'h1c, rd, rsp);
    chk("rresp", RESP_SLVERR, rsp);
  endtask
  task automatic t_class_a();
    logic [2:0] from [2] = '{MODE_4, MODE_6};
    logic [2:0] to [2] = '{MODE_3, MODE_5};
    for (int i = 0; i < 2; i++) begin
      pulse_mode(from[i]);
      pulse_mode(to[i]);
      chk1("fa_n", 1'b0, class_a_fault_n);
      chk1("fb_n", 1'b1, class_b_fault_n);
      enable_pin <= 1'b0;
      wt(5);
      chk1("disabled", 1'b1, device_disabled);
      rc("pstatus", ADDR_PSTATUS, 32'h10, 32'h0);
      rc("pin", ADDR_PIN, 32'h4, 32'h0);
      enable_pin <= 1'b1;
      wt(5);
      chk1("fa_n", 1'b1, class_a_fault_n);
    end
    pulse_mode(MODE_4);
    wr(ADDR_CTRL, 32'h1, rsp);
    class_a_event <= 1'b1;
    wt(1);
    class_a_event <= 1'b0;
    wt(3);
    chk1("fa_n", 1'b1, class_a_fault_n);
    rc("perr", ADDR_PERR, 32'h1, 32'h1);
    tristate_event <= 1'b1;
    wt(1);
    tristate_event <= 1'b0;
    wt(3);
    chk1("fa_n", 1'b0, class_a_fault_n);
    enable_pin <= 1'b0;
    wt(5);
    enable_pin <= 1'b1;
    wt(5);
    chk1("fa_n", 1'b0, class_a_fault_n);
    chk("en_events", 32'd3, ev_cnt);
    wr(ADDR_CTRL, 32'h1, rsp);
    chk1("fa_n", 1'b1, class_a_fault_n);
    rc("perr", ADDR_PERR, 32'hf, 32'h0);
  endtask
  task automatic t_class_b();
    int n;
    pulse_mode(MODE_0);
    class_b_event <= 1'b1;
    wt(1);
    class_b_event <= 1'b0;
    wt(3);
    chk1("fb_n", 1'b1, class_b_fault_n);
    rc("perr", ADDR_PERR, 32'h2, 32'h2);
    pulse_mode(MODE_1);
    chk1("fb_n", 1'b0, class_b_fault_n);
    n = mz_cnt;
    wr(ADDR_CTRL, 32'h2, rsp);
    wt(2);
    chk("mode0_req", n + 1, mz_cnt);
    chk1("fb_n", 1'b0, class_b_fault_n);
    pulse_mode(MODE_0);
    wr(ADDR_CTRL, 32'h1, rsp);
    chk1("fb_n", 1'b1, class_b_fault_n);
  endtask
  task automatic t_mask();
    {sec_class_a_in, sec_class_b_in} <= 2'h3;
    wt(5);
    rc("pstatus", ADDR_PSTATUS, 32'hc, 32'hc);
    rc("sstatus", ADDR_SSTATUS, 32'h3, 32'h3);
    rc("serr", ADDR_SERR, 32'h3, 32'h3);
    wr(ADDR_CFG, 32'h3, rsp);
    rc("cfg", ADDR_CFG, 32'h3, 32'h3);
    pulse_mode(MODE_1);
    pulse_mode(MODE_4);
    pulse_mode(MODE_3);
    wr(ADDR_CTRL, 32'h1, rsp);
    chk1("fa_n", 1'b0, class_a_fault_n);
    chk1("fb_n", 1'b0, class_b_fault_n);
    wr(ADDR_CTRL, 32'h2, rsp);
    rc("serr", ADDR_SERR, 32'h3, 32'h0);
    {sec_class_a_in, sec_class_b_in} <= 2'h0;
    wt(5);
    wr(ADDR_CTRL, 32'h1, rsp);
    chk1("fa_n", 1'b1, class_a_fault_n);
    chk1("fb_n", 1'b1, class_b_fault_n);
    wr(ADDR_CFG, 32'h0, rsp);
  endtask
  task automatic t_link();
    logic [11:0] bad [2] = '{12'h000, 12'h01e};
    int n, m;
    for (int i = 0; i < 2; i++) begin
      n = mz_cnt;
      period <= bad[i];
      for (int k = 0; k < 400 && class_b_fault_n !== 1'b0; k++) wt(1);
      if (class_b_fault_n !== 1'b0) tmo();
      wt(2);
      chk1("fb_n", 1'b0, class_b_fault_n);
      chk("mode0_req", n + 1, mz_cnt);
      rc("perr", ADDR_PERR, 32'h4, 32'h4);
      rc("serr", ADDR_SERR, 32'h4, 32'h4);
      rc("pstatus", ADDR_PSTATUS, 32'h20, 32'h0);
      period <= LS_PERIOD_CYC;
      m = ls_tog;
      wt(400);
      chk("ls_out", 32'd4, ls_tog - m);
      rc("pstatus", ADDR_PSTATUS, 32'h20, 32'h20);
      rc("perr", ADDR_PERR, 32'h4, 32'h4);
      wr(ADDR_CTRL, 32'h3, rsp);
    end
    period <= 12'h08c;
    wt(500);
    rc("perr", ADDR_PERR, 32'h4, 32'h0);
    period <= 12'h000;
    wt(160);
    wr(ADDR_CFG, 32'h2, rsp);
    wr(ADDR_CTRL, 32'h1, rsp);
    chk1("fb_n", 1'b0, class_b_fault_n);
    wr(ADDR_CFG, 32'h0, rsp);
  endtask
  task automatic t_hold();
    int m;
    pri_ref_current_fail <= 1'b1;
    wt(4);
    chk1("ready_n", 1'b0, reset_ready_n);
    chk1("sdo", 1'b1, sdo_low);
    chk1("fb_n", 1'b0, class_b_fault_n);
    pri_ref_current_fail <= 1'b0;
    wt(4);
    chk1("ready_n", 1'b1, reset_ready_n);
    for (int i = 0; i < 2; i++) begin
      {sec_ref_current_fail, sec_memory_fail} <= (i == 0) ? 2'h2 : 2'h1;
      wt(4);
      chk1("sec_off", 1'b1, sec_emergency_off);
      chk1("sec_hold", 1'b1, sec_hold_reset);
    end
    sec_memory_fail <= 1'b0;
    wt(4);
    chk1("sec_hold", 1'b0, sec_hold_reset);
    wr(ADDR_CFG, 32'h80, rsp);
    wt(4);
    chk1("ready_n", 1'b0, reset_ready_n);
    chk1("fb_n", 1'b0, class_b_fault_n);
    chk1("sec_off", 1'b1, sec_emergency_off);
    m = ls_tog;
    wt(200);
    chk("ls_frozen", 32'd0, ls_tog - m);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {sec_class_a_in, sec_class_b_in, pri_ref_current_fail, sec_ref_current_fail} = '0;
    {sec_memory_fail, class_a_event, class_b_event, tristate_event, aresetn} = '0;
    {n_fail, checks, mz_cnt, ev_cnt, ls_tog} = '0;
    ls_prev     = 1'b0;
    s_axi_wstrb = 4'hf;
    enable_pin  = 1'b1;
    op_mode     = MODE_0;
    period      = LS_PERIOD_CYC;
    wt(20);
    chk1("ready_n", 1'b0, reset_ready_n);
    chk1("fb_n", 1'b0, class_b_fault_n);
    chk1("fa_n", 1'b1, class_a_fault_n);
    chk1("sdo", 1'b1, sdo_low);
    aresetn <= 1'b1;
    wt(3);
    chk1("ready_n", 1'b1, reset_ready_n);
    t_regs();
    t_class_a();
    t_class_b();
    t_mask();
    t_link();
    t_hold();
    end_of_test();
  end
endmodule // fault_notify_supervision_tb
`default_nettype wire

// File: secondary_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module secondary_link_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] period,
  input  wire logic        hold,
  output var  logic        lifesign
);
  // ----------------------------------------
  // Lifesign source
  // ----------------------------------------
  logic [11:0] cnt;
  // Period 0 or a held secondary stops it, as a dead chip would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt      <= 12'h000;
      lifesign <= 1'b0;
    end else if (period != 12'h000 && !hold) begin
      cnt <= cnt + 12'h001;
      if (cnt + 12'h001 >= period) begin
        cnt      <= 12'h000;
        lifesign <= ~lifesign;
      end
    end
  end
endmodule // secondary_link_model
`default_nettype wire
